// File: crdvs_checker.sv
// Concurrent checks on the core rail voltage scaling block's ports.
// Assumes it is bound to the block and sees the same clock and reset.
`timescale 1ns/1ns
module crdvs_checker
#(
    parameter int STEP_BASE_CYCLES = crdvs_pkg::CRDVS_STEP_BASE_CYCLES
)
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic sda_oe_out,
    input wire logic core_default_strap_pin_in,
    input wire logic undervoltage_lockout_event_in,
    input wire logic warm_reset_pin_n_in,
    input wire logic power_on_reset_out_in,
    input wire logic backup_rail_low_in,
    input wire logic [2:0] buck_enabled_in,
    input wire logic [4:0] core_rail_output_code_out,
    input wire logic dynamic_voltage_move_busy_out,
    input wire logic [2:0] discharge_active_out
);
    import crdvs_pkg::*;
    logic quiet;
    logic calm;
    logic [2:0] quiet_hist_reg;
    logic [31:0] busy_count_reg;
    // Power events reload the rail code, so step checks wait until they are long gone.
    assign quiet = nrst_in && !undervoltage_lockout_event_in && warm_reset_pin_n_in
        && !power_on_reset_out_in && !backup_rail_low_in;
    assign calm = quiet && (&quiet_hist_reg);
    always_ff @(posedge clock_in)
    begin
        quiet_hist_reg <= nrst_in ? {quiet_hist_reg[1:0], quiet} : 3'h0;
    end
    always_ff @(posedge clock_in)
    begin
        busy_count_reg <= dynamic_voltage_move_busy_out ? busy_count_reg + 32'h0000_0001 : '0;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    AST_BUSY_RISE: assert property ($rose(dynamic_voltage_move_busy_out) |->
        sda_oe_out && $past(sda_oe_out)) else $error("move began without an acked write");
    AST_IDLE_STABLE: assert property (!dynamic_voltage_move_busy_out && calm
        && !$past(dynamic_voltage_move_busy_out) && !$past(dynamic_voltage_move_busy_out, 2)
        |-> $stable(core_rail_output_code_out)) else $error("rail code moved while idle");
    AST_BUSY_BOUND: assert property (busy_count_reg <= 32'(32 * STEP_BASE_CYCLES + 8))
        else $error("move bit never cleared");
    AST_DONE_STABLE: assert property ($fell(dynamic_voltage_move_busy_out) && calm |=>
        $stable(core_rail_output_code_out)[*3]) else $error("rail code moved after done");
    AST_STRAP_EVENT: assert property ((!quiet && $stable(core_default_strap_pin_in))[*4]
        |-> core_rail_output_code_out == (core_default_strap_pin_in ? 5'h1F : 5'h10))
        else $error("power event did not load strap code");
    AST_DISCHARGE: assert property ((discharge_active_out & $past(buck_enabled_in)) == 3'h0)
        else $error("discharge active on an enabled converter");
    AST_STEP_ONE: assert property ($changed(core_rail_output_code_out) && calm |->
        core_rail_output_code_out == $past(core_rail_output_code_out) + 5'h01
        || core_rail_output_code_out == $past(core_rail_output_code_out) - 5'h01)
        else $error("rail code stepped by more than one");
    AST_STEP_SPACING: assert property ($changed(core_rail_output_code_out) && calm |=>
        $stable(core_rail_output_code_out)[*3]) else $error("rail code steps too close");
endmodule

// File: crdvs_core_rail_dvs_control.sv
// Core rail voltage scaling control: target, slew, strap select, discharge.
// Assumes all pins are synchronous to clock_in and the host keeps its side.
`timescale 1ns/1ns
module crdvs_core_rail_dvs_control
#(
    parameter int STEP_BASE_CYCLES = crdvs_pkg::CRDVS_STEP_BASE_CYCLES
)
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic core_default_strap_pin_in,
    input wire logic undervoltage_lockout_event_in,
    input wire logic warm_reset_pin_n_in,
    input wire logic power_on_reset_out_in,
    input wire logic backup_rail_low_in,
    input wire logic [2:0] buck_enabled_in,
    output logic [4:0] core_rail_output_code_out,
    output logic dynamic_voltage_move_busy_out,
    output logic [2:0] discharge_active_out
);
    import crdvs_pkg::*;

    localparam int TIMER_WIDTH = $clog2(STEP_BASE_CYCLES + 1);

    crdvs_write_t bus_write;
    logic [7:0] read_addr;
    logic [7:0] read_data;
    logic soft_reset;
    logic move_reg;
    logic strap_select_reg;
    logic [2:0] discharge_reg;
    logic [4:0] target_reg;
    logic [2:0] slew_reg;
    logic [4:0] strap_code;
    logic [4:0] effective_target;
    logic [4:0] code_reg;
    logic load_default_reg;
    crdvs_ramp_t ramp_reg;
    logic [TIMER_WIDTH-1:0] timer_reg;
    logic [TIMER_WIDTH-1:0] interval;
    logic move_request;
    logic move_done;

    crdvs_serial_slave u_serial
    (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .read_data_in(read_data),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .read_addr_out(read_addr),
        .write_out(bus_write)
    );

    assign soft_reset = undervoltage_lockout_event_in || !warm_reset_pin_n_in
        || power_on_reset_out_in || backup_rail_low_in;

    assign strap_code = core_default_strap_pin_in ? CRDVS_CODE_STRAP_HIGH
        : CRDVS_CODE_STRAP_LOW;
    assign effective_target = strap_select_reg ? strap_code : target_reg;

    // Rate doubles per slew code, so the step interval halves.
    assign interval = TIMER_WIDTH'(STEP_BASE_CYCLES >> slew_reg);

    assign move_request = bus_write.strobe && bus_write.addr == CRDVS_ADDR_CONTROL_TWO
        && bus_write.data[CRDVS_BIT_MOVE];
    assign move_done = ramp_reg == CRDVS_RAMP_RUN && code_reg == effective_target;

    always_comb
    begin
        case (read_addr)
            CRDVS_ADDR_CONTROL_TWO:
            begin
                read_data = {move_reg, strap_select_reg, 3'b000, discharge_reg};
            end
            CRDVS_ADDR_VOLTAGE_TARGET:
            begin
                read_data = {3'b000, target_reg};
            end
            CRDVS_ADDR_SLEW_SELECT:
            begin
                read_data = {5'b00000, slew_reg};
            end
            default:
            begin
                read_data = 8'h00;
            end
        endcase
    end

    // Voltage target and strap select also fall back on the power events.
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in || soft_reset)
        begin
            target_reg <= CRDVS_RESET_TARGET;
            strap_select_reg <= CRDVS_RESET_STRAP_SELECT;
        end
        else if (bus_write.strobe)
        begin
            if (bus_write.addr == CRDVS_ADDR_VOLTAGE_TARGET)
            begin
                target_reg <= bus_write.data[4:0];
            end
            if (bus_write.addr == CRDVS_ADDR_CONTROL_TWO)
            begin
                strap_select_reg <= bus_write.data[CRDVS_BIT_STRAP_SELECT];
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            slew_reg <= CRDVS_RESET_SLEW;
            discharge_reg <= CRDVS_RESET_DISCHARGE;
        end
        else if (bus_write.strobe)
        begin
            if (bus_write.addr == CRDVS_ADDR_SLEW_SELECT)
            begin
                slew_reg <= bus_write.data[2:0];
            end
            if (bus_write.addr == CRDVS_ADDR_CONTROL_TWO)
            begin
                discharge_reg <= bus_write.data[2:0];
            end
        end
    end

    // A new request wins over a completion in the same cycle.
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            move_reg <= 1'b0;
        end
        else if (load_default_reg)
        begin
            // A power event abandons the ramp, so the bit must not stay stuck high.
            move_reg <= 1'b0;
        end
        else if (move_request)
        begin
            move_reg <= 1'b1;
        end
        else if (move_done)
        begin
            move_reg <= 1'b0;
        end
    end

    // The strap can only be read after reset release, so the start-up code
    // is loaded one cycle later rather than inside the reset branch.
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in || soft_reset)
        begin
            load_default_reg <= 1'b1;
        end
        else
        begin
            load_default_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            ramp_reg <= CRDVS_RAMP_IDLE;
            timer_reg <= '0;
            code_reg <= CRDVS_RESET_TARGET;
        end
        else if (load_default_reg)
        begin
            ramp_reg <= CRDVS_RAMP_IDLE;
            timer_reg <= '0;
            code_reg <= effective_target;
        end
        else
        begin
            case (ramp_reg)
                CRDVS_RAMP_IDLE:
                begin
                    if (move_request)
                    begin
                        ramp_reg <= CRDVS_RAMP_RUN;
                        timer_reg <= interval;
                    end
                end
                CRDVS_RAMP_RUN:
                begin
                    if (move_done)
                    begin
                        ramp_reg <= CRDVS_RAMP_IDLE;
                    end
                    else if (timer_reg <= TIMER_WIDTH'(1))
                    begin
                        timer_reg <= interval;
                        if (code_reg < effective_target)
                        begin
                            code_reg <= code_reg + 5'h01;
                        end
                        else
                        begin
                            code_reg <= code_reg - 5'h01;
                        end
                    end
                    else
                    begin
                        timer_reg <= timer_reg - TIMER_WIDTH'(1);
                    end
                end
                default:
                begin
                    ramp_reg <= CRDVS_RAMP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            core_rail_output_code_out <= CRDVS_RESET_TARGET;
            dynamic_voltage_move_busy_out <= 1'b0;
            discharge_active_out <= 3'b000;
        end
        else
        begin
            core_rail_output_code_out <= code_reg;
            dynamic_voltage_move_busy_out <= move_reg;
            discharge_active_out <= discharge_reg & ~buck_enabled_in;
        end
    end
endmodule

// File: crdvs_core_rail_dvs_control_tb_top.sv
// Self-checking bench for the core rail voltage scaling block.
// Assumes the host model drives the bus and the bench resolves the data wire.
`timescale 1ns/1ns
module crdvs_core_rail_dvs_control_tb_top;
    import crdvs_pkg::*;
    localparam int STEP_BASE = 512;
    logic clock_in = 1'b0;
    logic nrst_in, scl, host_low, sda_wire, sda_out, sda_oe_out, strap, undervoltage_lockout_event, warm_n, por, vlow;
    logic busy;
    logic [2:0] buck, disch;
    logic [4:0] code;
    logic [4:0] last_code;
    logic [15:0] gap_count, step_gap;
    logic [7:0] exp_code;
    int n_fail = 0;
    int samples_checked = 0;
    always #4 clock_in = ~clock_in;
    assign sda_wire = ~(host_low | sda_oe_out);
    crdvs_host_model u_crdvs_host_model (.clock_in(clock_in), .sda_wire_in(sda_wire),
        .scl_out(scl), .sda_low_out(host_low));
    crdvs_core_rail_dvs_control #(.STEP_BASE_CYCLES(STEP_BASE)) u_crdvs_core_rail_dvs_control (
        .clock_in(clock_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .core_default_strap_pin_in(strap),
        .undervoltage_lockout_event_in(undervoltage_lockout_event), .warm_reset_pin_n_in(warm_n),
        .power_on_reset_out_in(por), .backup_rail_low_in(vlow), .buck_enabled_in(buck),
        .core_rail_output_code_out(code), .dynamic_voltage_move_busy_out(busy),
        .discharge_active_out(disch));
    // The gap between the last two rail code changes gives the step interval.
    always @(posedge clock_in)
    begin
        gap_count <= (code !== last_code) ? 16'h0000 : gap_count + 16'h0001;
        if (code !== last_code)
            step_gap <= gap_count + 16'h0001;
        last_code <= code;
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_crdvs_host_model.write_reg(CRDVS_DEVICE_ADDRESS, a, d, ok);
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_crdvs_host_model.read_reg(a, d);
        check_val(d, exp);
    endtask
    task automatic wait_done(input logic [7:0] exp);
        for (int k = 0; k < 20000 && busy !== 1'b0; k++)
            @(posedge clock_in);
        rd_check(CRDVS_ADDR_CONTROL_TWO, 8'h00);
        check_val(code, exp);
    endtask
    task automatic test_reset_values;
        rd_check(CRDVS_ADDR_CONTROL_TWO, 8'h40);
        rd_check(CRDVS_ADDR_VOLTAGE_TARGET, 8'h14);
        rd_check(CRDVS_ADDR_SLEW_SELECT, 8'h06);
        rd_check(8'h09, 8'h00);
        check_val(sda_out, 16'h0000);
        check_val(code, 16'h0010);
    endtask
    task automatic test_events;
        strap <= 1'b1;
        for (int e = 0; e < 4; e++)
        begin
            wr(CRDVS_ADDR_VOLTAGE_TARGET, 8'h03);
            wr(CRDVS_ADDR_CONTROL_TWO, 8'h00);
            @(posedge clock_in);
            undervoltage_lockout_event <= (e == 0);
            warm_n <= (e != 1);
            por <= (e == 2);
            vlow <= (e == 3);
            repeat (6) @(posedge clock_in);
            check_val(code, 16'h001F);
            undervoltage_lockout_event <= 1'b0;
            warm_n <= 1'b1;
            por <= 1'b0;
            vlow <= 1'b0;
            repeat (4) @(posedge clock_in);
            rd_check(CRDVS_ADDR_VOLTAGE_TARGET, 8'h14);
            rd_check(CRDVS_ADDR_CONTROL_TWO, 8'h40);
        end
    endtask
    task automatic test_ramp;
        wr(CRDVS_ADDR_VOLTAGE_TARGET, 8'h12);
        wr(CRDVS_ADDR_SLEW_SELECT, 8'h07);
        wr(CRDVS_ADDR_CONTROL_TWO, 8'h80);
        wait_done(8'h12);
        wr(CRDVS_ADDR_VOLTAGE_TARGET, 8'h0A);
        wr(CRDVS_ADDR_CONTROL_TWO, 8'h00);
        repeat (40) @(posedge clock_in);
        check_val(code, 16'h0012);
    endtask
    task automatic test_slew;
        exp_code = 8'h12;
        for (int s = 0; s < 8; s++)
        begin
            exp_code = s[0] ? exp_code - 8'h02 : exp_code + 8'h02;
            wr(CRDVS_ADDR_SLEW_SELECT, 8'(s));
            wr(CRDVS_ADDR_VOLTAGE_TARGET, exp_code);
            wr(CRDVS_ADDR_CONTROL_TWO, 8'h80);
            wait_done(exp_code);
            check_val(step_gap, 16'(STEP_BASE >> s));
        end
    endtask
    task automatic test_discharge;
        wr(CRDVS_ADDR_CONTROL_TWO, 8'h3F);
        rd_check(CRDVS_ADDR_CONTROL_TWO, 8'h07);
        check_val(disch, 16'h0000);
        buck <= 3'b010;
        repeat (3) @(posedge clock_in);
        check_val(disch, 16'h0005);
        wr(CRDVS_ADDR_CONTROL_TWO, 8'h02);
        check_val(disch, 16'h0000);
        buck <= 3'b000;
        repeat (3) @(posedge clock_in);
        check_val(disch, 16'h0002);
    endtask
    task automatic test_wrong_device;
        logic ok;
        u_crdvs_host_model.write_reg(CRDVS_DEVICE_ADDRESS ^ 7'h01, CRDVS_ADDR_SLEW_SELECT,
            8'h01, ok);
        check_val(ok, 16'h0000);
        rd_check(CRDVS_ADDR_SLEW_SELECT, 8'h07);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge clock_in);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end
    initial
    begin
        nrst_in = 1'b0;
        strap = 1'b0;
        undervoltage_lockout_event = 1'b0;
        warm_n = 1'b1;
        por = 1'b0;
        vlow = 1'b0;
        buck = 3'b111;
        repeat (12) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (5) @(posedge clock_in);
        test_reset_values();
        test_events();
        test_ramp();
        test_slew();
        test_discharge();
        test_wrong_device();
        stop_test();
    end
endmodule
bind crdvs_core_rail_dvs_control crdvs_checker #(.STEP_BASE_CYCLES(STEP_BASE_CYCLES))
    u_crdvs_checker (.clock_in(clock_in), .nrst_in(nrst_in), .sda_oe_out(sda_oe_out),
    .core_default_strap_pin_in(core_default_strap_pin_in),
    .undervoltage_lockout_event_in(undervoltage_lockout_event_in),
    .warm_reset_pin_n_in(warm_reset_pin_n_in), .power_on_reset_out_in(power_on_reset_out_in),
    .backup_rail_low_in(backup_rail_low_in), .buck_enabled_in(buck_enabled_in),
    .core_rail_output_code_out(core_rail_output_code_out),
    .dynamic_voltage_move_busy_out(dynamic_voltage_move_busy_out),
    .discharge_active_out(discharge_active_out));

// File: crdvs_host_model.sv
// Host side of the two-wire register bus: start, stop, bytes, register access.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module crdvs_host_model
(
    input wire logic clock_in,
    input wire logic sda_wire_in,
    output logic scl_out,
    output logic sda_low_out
);
    import crdvs_pkg::*;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Each clock phase lasts five cycles, with sda set four cycles before scl moves.
    task automatic phase(input logic scl, input logic low);
        @(posedge clock_in);
        sda_low_out <= low;
        repeat (4) @(posedge clock_in);
        scl_out <= scl;
    endtask
    task automatic bit_io(input logic b, output logic r);
        phase(1'b1, ~b);
        repeat (4) @(posedge clock_in);
        r = sda_wire_in;
        scl_out <= 1'b0;
    endtask
    task automatic start_cond;
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b1);
    endtask
    task automatic stop_cond;
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
    endtask
    task automatic send_byte(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ok = ok & ~r;
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
        output logic ok);
        ok = 1'b1;
        start_cond();
        send_byte({dev, 1'b0}, ok);
        send_byte(a, ok);
        send_byte(d, ok);
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic ok;
        logic r;
        ok = 1'b1;
        start_cond();
        send_byte({CRDVS_DEVICE_ADDRESS, 1'b0}, ok);
        send_byte(a, ok);
        start_cond();
        send_byte({CRDVS_DEVICE_ADDRESS, 1'b1}, ok);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
        stop_cond();
    endtask
endmodule

// File: crdvs_pkg.sv
// Shared constants and types for the core rail voltage scaling block.
// Assumes a 125 MHz system clock and the serial register map below.
package crdvs_pkg;

    // Register addresses on the serial interface.
    localparam logic [7:0] CRDVS_ADDR_CONTROL_TWO = 8'h05;
    localparam logic [7:0] CRDVS_ADDR_VOLTAGE_TARGET = 8'h06;
    localparam logic [7:0] CRDVS_ADDR_SLEW_SELECT = 8'h07;

    // Field positions.
    localparam int CRDVS_BIT_MOVE = 7;
    localparam int CRDVS_BIT_STRAP_SELECT = 6;
    localparam int CRDVS_BIT_DISCH_SYSTEM = 2;
    localparam int CRDVS_BIT_DISCH_CORE = 1;
    localparam int CRDVS_BIT_DISCH_MEMORY = 0;

    // Reset values.
    localparam logic [4:0] CRDVS_RESET_TARGET = 5'h14;
    localparam logic [2:0] CRDVS_RESET_SLEW = 3'h6;
    localparam logic CRDVS_RESET_STRAP_SELECT = 1'b1;
    localparam logic [2:0] CRDVS_RESET_DISCHARGE = 3'h0;

    // Voltage code: 0.8 V at code zero, 25 mV per step.
    localparam int CRDVS_CODE_BASE_MV = 800;
    localparam int CRDVS_STEP_UV = 25000;
    localparam logic [4:0] CRDVS_CODE_STRAP_LOW = 5'(((1200 - CRDVS_CODE_BASE_MV) * 1000)
        / CRDVS_STEP_UV);
    // The top code is pinned to 1.6 V; the 25 mV line alone would overflow five bits.
    localparam logic [4:0] CRDVS_CODE_STRAP_HIGH = 5'h1F;

    // Slowest slew is 0.225 mV/us; each slew code step doubles the rate.
    localparam int CRDVS_CLK_PERIOD_NS = 8;
    localparam int CRDVS_SLEW_BASE_UV_PER_US = 225;
    localparam int CRDVS_STEP_BASE_CYCLES = (CRDVS_STEP_UV * 1000)
        / (CRDVS_SLEW_BASE_UV_PER_US * CRDVS_CLK_PERIOD_NS);

    // Serial device address; the value is arbitrary.
    localparam logic [6:0] CRDVS_DEVICE_ADDRESS = 7'h48;

    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } crdvs_write_t;

    typedef enum logic [0:0] {
        CRDVS_RAMP_IDLE = 1'b0,
        CRDVS_RAMP_RUN = 1'b1
    } crdvs_ramp_t;

    typedef enum logic [1:0] {
        CRDVS_SER_RX = 2'b00,
        CRDVS_SER_ACK_TX = 2'b01,
        CRDVS_SER_TX = 2'b10,
        CRDVS_SER_ACK_RX = 2'b11
    } crdvs_ser_t;

    typedef enum logic [1:0] {
        CRDVS_BYTE_ADDR = 2'b00,
        CRDVS_BYTE_PTR = 2'b01,
        CRDVS_BYTE_DATA = 2'b10,
        CRDVS_BYTE_NONE = 2'b11
    } crdvs_byte_t;

endpackage

// File: crdvs_serial_slave.sv
// Serial two-wire register slave: address, register pointer, data bytes.
// Assumes scl and sda are already synchronous to the clock.
`timescale 1ns/1ns
module crdvs_serial_slave
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [7:0] read_data_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [7:0] read_addr_out,
    output crdvs_pkg::crdvs_write_t write_out
);
    import crdvs_pkg::*;

    logic scl_prev_reg;
    logic sda_prev_reg;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    crdvs_ser_t state_reg;
    crdvs_byte_t kind_reg;
    logic [3:0] count_reg;
    logic [7:0] shift_reg;
    logic read_reg;
    logic nack_reg;

    assign start_seen = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
    assign stop_seen = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
    assign scl_rise = scl_in && !scl_prev_reg;
    assign scl_fall = !scl_in && scl_prev_reg;

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
            sda_out <= 1'b0;
        end
    end

    // Open-drain: the pin is only ever pulled low, never driven high.
    always_ff @(posedge clock_in)
    begin
        write_out.strobe <= 1'b0;
        if (!nrst_in)
        begin
            state_reg <= CRDVS_SER_RX;
            kind_reg <= CRDVS_BYTE_NONE;
            count_reg <= 4'h0;
            shift_reg <= 8'h00;
            read_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe_out <= 1'b0;
            read_addr_out <= 8'h00;
            write_out <= '0;
        end
        else if (start_seen)
        begin
            state_reg <= CRDVS_SER_RX;
            kind_reg <= CRDVS_BYTE_ADDR;
            count_reg <= 4'h0;
            sda_oe_out <= 1'b0;
        end
        else if (stop_seen)
        begin
            state_reg <= CRDVS_SER_RX;
            kind_reg <= CRDVS_BYTE_NONE;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            case (state_reg)
                CRDVS_SER_RX:
                begin
                    if (scl_rise && kind_reg != CRDVS_BYTE_NONE)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_in};
                        count_reg <= count_reg + 4'h1;
                    end
                    else if (scl_fall && count_reg == 4'h8)
                    begin
                        count_reg <= 4'h0;
                        state_reg <= CRDVS_SER_ACK_TX;
                        sda_oe_out <= 1'b1;
                        if (kind_reg == CRDVS_BYTE_ADDR)
                        begin
                            read_reg <= shift_reg[0];
                            if (shift_reg[7:1] != CRDVS_DEVICE_ADDRESS)
                            begin
                                kind_reg <= CRDVS_BYTE_NONE;
                                state_reg <= CRDVS_SER_RX;
                                sda_oe_out <= 1'b0;
                            end
                        end
                        else if (kind_reg == CRDVS_BYTE_PTR)
                        begin
                            read_addr_out <= shift_reg;
                        end
                        else
                        begin
                            write_out.strobe <= 1'b1;
                            write_out.addr <= read_addr_out;
                            write_out.data <= shift_reg;
                            read_addr_out <= read_addr_out + 8'h01;
                        end
                    end
                end
                CRDVS_SER_ACK_TX:
                begin
                    if (scl_fall)
                    begin
                        if (kind_reg == CRDVS_BYTE_ADDR && read_reg)
                        begin
                            shift_reg <= read_data_in;
                            sda_oe_out <= !read_data_in[7];
                            read_addr_out <= read_addr_out + 8'h01;
                            state_reg <= CRDVS_SER_TX;
                        end
                        else
                        begin
                            sda_oe_out <= 1'b0;
                            state_reg <= CRDVS_SER_RX;
                        end
                        if (kind_reg == CRDVS_BYTE_ADDR)
                        begin
                            kind_reg <= read_reg ? CRDVS_BYTE_DATA : CRDVS_BYTE_PTR;
                        end
                        else
                        begin
                            kind_reg <= CRDVS_BYTE_DATA;
                        end
                    end
                end
                CRDVS_SER_TX:
                begin
                    if (scl_fall)
                    begin
                        if (count_reg == 4'h7)
                        begin
                            count_reg <= 4'h0;
                            sda_oe_out <= 1'b0;
                            state_reg <= CRDVS_SER_ACK_RX;
                        end
                        else
                        begin
                            count_reg <= count_reg + 4'h1;
                            sda_oe_out <= !shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                CRDVS_SER_ACK_RX:
                begin
                    if (scl_rise)
                    begin
                        nack_reg <= sda_in;
                    end
                    else if (scl_fall)
                    begin
                        if (!nack_reg)
                        begin
                            shift_reg <= read_data_in;
                            sda_oe_out <= !read_data_in[7];
                            read_addr_out <= read_addr_out + 8'h01;
                            state_reg <= CRDVS_SER_TX;
                        end
                        else
                        begin
                            kind_reg <= CRDVS_BYTE_NONE;
                            state_reg <= CRDVS_SER_RX;
                        end
                    end
                end
                default:
                begin
                    state_reg <= CRDVS_SER_RX;
                end
            endcase
        end
    end
endmodule
